// ===== src/sar_adc_ctrl.sv
// What this block does
// - Eight channels, each with own selects
// - Positive select set means channel enabled
// - One channel one-shot, several channels scan
// - Negative select used only when differential
// - Single-ended default; negative input grounded
// - Result scaled by resolution minus mode
// - 8/10/12 bits; 14 only oversampled
// - Stored samples are 16-bit signed
// - Scan spacing: acquisition plus conversion
// - Sample task from software or interconnect
// - Offset calibration ends with done event
// - Events on each sample, buffer full
// - Selects: eight pins, supply, or none
// - Internal timer repeats single-channel sampling
// - Own DMA writes every result; oversampled runs store only the averages
// - Limits checked as results appear
// - Per-channel gain field
// - One task converts each enabled channel if not oversampling
// - Sign-extended little-endian; end when full
// - Stop ends sampling, always signals stopped
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event interconnect
  input wire logic sample_evt,
  output logic [7:0] events,
  // Analog core
  output logic [3:0] core_pos_sel,
  output logic [3:0] core_neg_sel,
  output logic core_neg_gnd,
  output logic [2:0] core_gain,
  output logic core_ref_sel,
  output logic core_start,
  output logic core_calib,
  input wire logic core_done,
  input wire logic [14:0] core_code,
  // Result DMA
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack
);
  typedef struct packed {
    logic [7:0][3:0] positive_input_select;
    logic [7:0][3:0] negative_input_select;
    logic [7:0][31:0] cfg;
    logic [7:0][31:0] lim;
    logic [1:0] res;
    logic [3:0] os;
    logic [12:0] srate;
    logic [31:0] ptr;
    logic [31:0] ptr_act;
    logic [14:0] maxcnt;
    logic [14:0] amount;
    logic running;
    sar_pkg::fsm_t fsm;
    logic [2:0] ch;
    logic [15:0] acq_cnt;
    logic [11:0] tmr;
    logic [23:0] acc;
    logic [7:0] os_cnt;
    logic [15:0] val;
    logic [7:0] evt;
    logic [7:0] evp;
    logic rd_ok;
    logic err;
    logic [31:0] prdata;
    logic [3:0] pos;
    logic [3:0] neg;
    logic neg_gnd;
    logic [2:0] gain;
    logic ref_sel;
    logic start;
    logic calib;
    logic done_q;
    logic mem_req;
  } regs_t;
  regs_t st_ff;
  regs_t nxt_st;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic sel_on(input logic [3:0] s);
    return (s != sar_pkg::SEL_NC) && (s <= sar_pkg::SEL_VDD);
  endfunction

  // Lowest enabled channel at or above from; bit 3 flags a hit
  function automatic logic [3:0] pick(input logic [7:0] en,
                                      input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && 4'(i) >= from) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pins, bus strobes, channel state
  // ----------------------------------------------------------------
  logic [15:0] sync_q;
  logic done_s;
  logic [14:0] code_s;
  logic [15:0] shaped;
  logic [7:0] en;
  logic scan;
  logic acc_ph;
  logic wr;
  logic t_start;
  logic t_sample;
  logic t_stop;
  logic t_cal;
  logic done_rise;
  logic os_on;

  level_sync #(.W(16)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({core_done, core_code}),
    .q(sync_q)
  );
  assign done_s = sync_q[15];
  assign code_s = sync_q[14:0];
  assign done_rise = done_s && !st_ff.done_q;
  assign os_on = st_ff.os != 4'h0;

  result_shaper u_shape (
    .raw(code_s),
    .res(st_ff.res),
    .diff(st_ff.cfg[st_ff.ch][sar_pkg::CFG_MODE_BIT]),
    .os_on(os_on),
    .value(shaped)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_en
      assign en[g] = sel_on(st_ff.positive_input_select[g]);
    end
  endgenerate
  assign scan = (en & (en - 8'h01)) != 8'h00;

  assign acc_ph = psel && penable;
  assign wr = acc_ph && st_ff.rd_ok && pwrite;
  assign t_start = wr && paddr == sar_pkg::OFS_TASK_START && pwdata[0];
  assign t_sample = wr && paddr == sar_pkg::OFS_TASK_SAMPLE && pwdata[0];
  assign t_stop = wr && paddr == sar_pkg::OFS_TASK_STOP && pwdata[0];
  assign t_cal = wr && paddr == sar_pkg::OFS_TASK_CAL && pwdata[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic is_ch;
    logic [2:0] ai;
    logic [1:0] sub;
    logic [31:0] rdv;
    logic go;
    logic [3:0] nx;
    logic [7:0] clr;
    logic hit;
    logic [23:0] sum;
    is_ch = paddr[11:7] == sar_pkg::OFS_CH_BASE[11:7];
    ai = paddr[6:4];
    sub = paddr[3:2];
    rdv = 32'h0000_0000;
    go = 1'b0;
    nx = 4'h0;
    clr = 8'h00;
    hit = 1'b0;
    sum = 24'h00_0000;
    nxt_st = st_ff;
    nxt_st.evp = 8'h00;
    nxt_st.start = 1'b0;
    nxt_st.calib = 1'b0;
    nxt_st.done_q = done_s;

    // Read data is registered, so every access waits one cycle
    nxt_st.rd_ok = acc_ph && !st_ff.rd_ok;
    unique case (1'b1)
      is_ch: begin
        unique case (sub)
          sar_pkg::CH_POSITIVE_INPUT_SELECT: rdv = {28'h0, st_ff.positive_input_select[ai]};
          sar_pkg::CH_NEGATIVE_INPUT_SELECT: rdv = {28'h0, st_ff.negative_input_select[ai]};
          sar_pkg::CH_CFG: rdv = st_ff.cfg[ai];
          sar_pkg::CH_LIMIT: rdv = st_ff.lim[ai];
        endcase
      end
      paddr == sar_pkg::OFS_EVENTS: rdv = {24'h0, st_ff.evt};
      paddr == sar_pkg::OFS_STATUS:
        rdv = {24'h0, st_ff.running, st_ff.fsm != sar_pkg::S_IDLE,
               scan, 2'h0, st_ff.ch};
      paddr == sar_pkg::OFS_RESOLUTION: rdv = {30'h0, st_ff.res};
      paddr == sar_pkg::OFS_OVERSAMPLE: rdv = {28'h0, st_ff.os};
      paddr == sar_pkg::OFS_SAMPLERATE: rdv = {19'h0, st_ff.srate};
      paddr == sar_pkg::OFS_RESULT_PTR: rdv = st_ff.ptr;
      paddr == sar_pkg::OFS_MAXCNT: rdv = {17'h0, st_ff.maxcnt};
      paddr == sar_pkg::OFS_AMOUNT: rdv = {17'h0, st_ff.amount};
      default: rdv = 32'h0000_0000;
    endcase
    if (acc_ph && !st_ff.rd_ok) begin
      nxt_st.prdata = pwrite ? 32'h0000_0000 : rdv;
      nxt_st.err = !(is_ch || paddr == sar_pkg::OFS_EVENTS ||
        paddr == sar_pkg::OFS_STATUS || paddr[11:8] == 4'h0 &&
        paddr[7:4] == 4'h0 || paddr == sar_pkg::OFS_RESOLUTION ||
        paddr == sar_pkg::OFS_OVERSAMPLE ||
        paddr == sar_pkg::OFS_SAMPLERATE ||
        paddr == sar_pkg::OFS_RESULT_PTR ||
        paddr == sar_pkg::OFS_MAXCNT || paddr == sar_pkg::OFS_AMOUNT);
    end

    if (wr) begin
      if (is_ch) begin
        unique case (sub)
          sar_pkg::CH_POSITIVE_INPUT_SELECT: nxt_st.positive_input_select[ai] = pwdata[3:0];
          sar_pkg::CH_NEGATIVE_INPUT_SELECT: nxt_st.negative_input_select[ai] = pwdata[3:0];
          sar_pkg::CH_CFG: nxt_st.cfg[ai] = pwdata;
          sar_pkg::CH_LIMIT: nxt_st.lim[ai] = pwdata;
        endcase
      end
      if (paddr == sar_pkg::OFS_EVENTS) clr = pwdata[7:0];
      if (paddr == sar_pkg::OFS_RESOLUTION) nxt_st.res = pwdata[1:0];
      if (paddr == sar_pkg::OFS_OVERSAMPLE) nxt_st.os = pwdata[3:0];
      if (paddr == sar_pkg::OFS_SAMPLERATE) nxt_st.srate = pwdata[12:0];
      if (paddr == sar_pkg::OFS_RESULT_PTR) nxt_st.ptr = pwdata;
      if (paddr == sar_pkg::OFS_MAXCNT) nxt_st.maxcnt = pwdata[14:0];
    end

    // Local timer only paces single-channel runs
    if (!(st_ff.running && st_ff.srate[sar_pkg::SRATE_MODE_BIT]) || scan) begin
      nxt_st.tmr = st_ff.srate[11:0];
    end else if (st_ff.tmr == 12'h000) begin
      nxt_st.tmr = st_ff.srate[11:0];
      hit = st_ff.srate[11:0] != 12'h000;
    end else begin
      nxt_st.tmr = st_ff.tmr - 12'h001;
    end

    if (t_start) begin
      nxt_st.ptr_act = st_ff.ptr;
      nxt_st.amount = 15'h0000;
      nxt_st.running = 1'b1;
      nxt_st.acc = 24'h00_0000;
      nxt_st.os_cnt = 8'h00;
      nxt_st.evp[sar_pkg::EV_STARTED] = 1'b1;
    end

    unique case (st_ff.fsm)
      sar_pkg::S_IDLE: begin
        nx = pick(en, 4'h0);
        if (t_cal) begin
          nxt_st.calib = 1'b1;
          nxt_st.fsm = sar_pkg::S_CAL;
        end else if ((t_sample || sample_evt || hit) && st_ff.running &&
                     nx[3]) begin
          go = 1'b1;
        end
      end
      sar_pkg::S_CAL: begin
        if (done_rise) begin
          nxt_st.evp[sar_pkg::EV_CALDONE] = 1'b1;
          nxt_st.fsm = sar_pkg::S_IDLE;
        end
      end
      sar_pkg::S_ACQ: begin
        if (st_ff.acq_cnt == 16'h0000) begin
          nxt_st.start = 1'b1;
          nxt_st.fsm = sar_pkg::S_CONV;
        end else begin
          nxt_st.acq_cnt = st_ff.acq_cnt - 16'h0001;
        end
      end
      sar_pkg::S_CONV: begin
        if (done_rise) begin
          nxt_st.evp[sar_pkg::EV_DONE] = 1'b1;
          // Out-of-range flags appear with the result itself
          if ($signed(shaped) > $signed(st_ff.lim[st_ff.ch][31:16])) begin
            nxt_st.evp[sar_pkg::EV_LIMH] = 1'b1;
          end
          if ($signed(shaped) < $signed(st_ff.lim[st_ff.ch][15:0])) begin
            nxt_st.evp[sar_pkg::EV_LIML] = 1'b1;
          end
          if (os_on) begin
            sum = st_ff.acc + {{8{shaped[15]}}, shaped};
            if (st_ff.os_cnt + 8'h01 == 8'(9'h001 << st_ff.os)) begin
              nxt_st.val = 16'($signed(sum) >>> st_ff.os);
              nxt_st.acc = 24'h00_0000;
              nxt_st.os_cnt = 8'h00;
              nxt_st.mem_req = 1'b1;
              nxt_st.fsm = sar_pkg::S_STORE;
            end else begin
              nxt_st.acc = sum;
              nxt_st.os_cnt = st_ff.os_cnt + 8'h01;
              nxt_st.fsm = sar_pkg::S_IDLE;
            end
          end else begin
            nxt_st.val = shaped;
            nxt_st.mem_req = 1'b1;
            nxt_st.fsm = sar_pkg::S_STORE;
          end
        end
      end
      sar_pkg::S_STORE: begin
        if (mem_ack) begin
          nxt_st.mem_req = 1'b0;
          nxt_st.amount = st_ff.amount + 15'h0001;
          nxt_st.evp[sar_pkg::EV_RESULTDONE] = 1'b1;
          nx = pick(en, {1'b0, st_ff.ch} + 4'h1);
          if (st_ff.amount + 15'h0001 == st_ff.maxcnt) begin
            nxt_st.evp[sar_pkg::EV_END] = 1'b1;
            nxt_st.running = 1'b0;
            nxt_st.fsm = sar_pkg::S_IDLE;
          end else if (scan && nx[3]) begin
            go = 1'b1;
          end else begin
            nxt_st.fsm = sar_pkg::S_IDLE;
          end
        end
      end
    endcase

    if (go) begin
      nxt_st.ch = nx[2:0];
      nxt_st.fsm = sar_pkg::S_ACQ;
      nxt_st.pos = st_ff.positive_input_select[nx[2:0]];
      // Negative mux only matters in differential mode
      nxt_st.neg_gnd = !st_ff.cfg[nx[2:0]][sar_pkg::CFG_MODE_BIT];
      nxt_st.neg = nxt_st.neg_gnd ? sar_pkg::SEL_NC :
                   st_ff.negative_input_select[nx[2:0]];
      nxt_st.gain = st_ff.cfg[nx[2:0]][sar_pkg::CFG_GAIN_LSB +: 3];
      nxt_st.ref_sel = st_ff.cfg[nx[2:0]][sar_pkg::CFG_REF_BIT];
      nxt_st.acq_cnt = 16'(({13'h0,
        st_ff.cfg[nx[2:0]][sar_pkg::CFG_ACQUISITION_TIME_LSB +: 3]} + 16'h0001) *
        sar_pkg::ACQ_UNIT_CYC);
    end

    if (t_stop) begin
      nxt_st.running = 1'b0;
      nxt_st.mem_req = 1'b0;
      nxt_st.start = 1'b0;
      nxt_st.evp[sar_pkg::EV_STOPPED] = 1'b1;
      if (st_ff.fsm != sar_pkg::S_CAL) nxt_st.fsm = sar_pkg::S_IDLE;
    end
    // A new event beats a same-cycle clear
    nxt_st.evt = (st_ff.evt & ~clr) | nxt_st.evp;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.cfg <= {8{sar_pkg::CFG_RST}};
      st_ff.lim <= {8{sar_pkg::LIMIT_RST}};
      st_ff.res <= sar_pkg::RES_RST;
      st_ff.fsm <= sar_pkg::S_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st_ff.prdata;
  assign pready = acc_ph && st_ff.rd_ok;
  assign pslverr = pready && st_ff.err;
  assign events = st_ff.evp;
  assign core_pos_sel = st_ff.pos;
  assign core_neg_sel = st_ff.neg;
  assign core_neg_gnd = st_ff.neg_gnd;
  assign core_gain = st_ff.gain;
  assign core_ref_sel = st_ff.ref_sel;
  assign core_start = st_ff.start;
  assign core_calib = st_ff.calib;
  assign mem_req = st_ff.mem_req;
  // Halfword slots, low address first: little-endian packing
  assign mem_addr = st_ff.ptr_act + {16'h0, st_ff.amount, 1'b0};
  assign mem_wdata = st_ff.val;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_stop_gives_stopped: assert property (t_stop |=>
    events[sar_pkg::EV_STOPPED] && st_ff.fsm != sar_pkg::S_CONV)
    else $error("stop task without stopped event");
  a_empty_no_conv: assert property (
    (st_ff.fsm == sar_pkg::S_IDLE && en == 8'h00 && !t_cal) |=>
    st_ff.fsm == sar_pkg::S_IDLE && !core_start)
    else $error("conversion with no channel enabled");
  a_se_grounds_neg: assert property (core_start |->
    core_neg_gnd == !st_ff.cfg[st_ff.ch][sar_pkg::CFG_MODE_BIT])
    else $error("negative input grounding wrong");
  a_dma_holds: assert property ((mem_req && !mem_ack && !t_stop) |=>
    mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("dma request dropped or changed");
  a_end_when_full: assert property (
    events[sar_pkg::EV_END] |-> st_ff.amount == st_ff.maxcnt && !mem_req)
    else $error("end event with buffer not full");
  a_scan_ascends: assert property (
    (st_ff.fsm == sar_pkg::S_STORE && nxt_st.fsm == sar_pkg::S_ACQ) |=>
    st_ff.ch > $past(st_ff.ch))
    else $error("scan order not ascending");
  a_acq_then_conv: assert property (
    (st_ff.fsm == sar_pkg::S_ACQ && st_ff.acq_cnt == 16'h0000 && !t_stop)
    |=> core_start ##1 st_ff.fsm == sar_pkg::S_CONV && !core_start)
    else $error("acquisition did not end in conversion");
  a_cal_done_evt: assert property (
    (st_ff.fsm == sar_pkg::S_CAL && done_rise) |=>
    events[sar_pkg::EV_CALDONE] && st_ff.fsm == sar_pkg::S_IDLE)
    else $error("calibration done event missing");

  c_buffer_full: cover property (events[sar_pkg::EV_END]);
  c_scan_step: cover property (st_ff.fsm == sar_pkg::S_STORE ##1
    st_ff.fsm == sar_pkg::S_ACQ);
  c_calibrated: cover property (events[sar_pkg::EV_CALDONE]);
endmodule
`default_nettype wire

// ===== src/sar_pkg.sv
`default_nettype none
package sar_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ACQ_UNIT_NS = 1000;
  localparam logic [15:0] ACQ_UNIT_CYC = 16'(ACQ_UNIT_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TASK_START = 12'h000;
  localparam logic [11:0] OFS_TASK_SAMPLE = 12'h004;
  localparam logic [11:0] OFS_TASK_STOP = 12'h008;
  localparam logic [11:0] OFS_TASK_CAL = 12'h00C;
  localparam logic [11:0] OFS_EVENTS = 12'h100;
  localparam logic [11:0] OFS_STATUS = 12'h400;
  localparam logic [11:0] OFS_CH_BASE = 12'h500;
  localparam logic [1:0] CH_POSITIVE_INPUT_SELECT = 2'h0;
  localparam logic [1:0] CH_NEGATIVE_INPUT_SELECT = 2'h1;
  localparam logic [1:0] CH_CFG = 2'h2;
  localparam logic [1:0] CH_LIMIT = 2'h3;
  localparam logic [11:0] OFS_RESOLUTION = 12'h5F0;
  localparam logic [11:0] OFS_OVERSAMPLE = 12'h5F4;
  localparam logic [11:0] OFS_SAMPLERATE = 12'h5F8;
  localparam logic [11:0] OFS_RESULT_PTR = 12'h62C;
  localparam logic [11:0] OFS_MAXCNT = 12'h630;
  localparam logic [11:0] OFS_AMOUNT = 12'h634;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_GAIN_LSB = 8;
  localparam int unsigned CFG_REF_BIT = 12;
  localparam int unsigned CFG_ACQUISITION_TIME_LSB = 16;
  localparam int unsigned CFG_MODE_BIT = 20;
  localparam int unsigned SRATE_MODE_BIT = 12;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h7FFF_8000;
  localparam logic [1:0] RES_RST = 2'h1;
  localparam logic [3:0] SEL_NC = 4'h0;
  localparam logic [3:0] SEL_VDD = 4'h9;
  localparam logic [1:0] RES_14 = 2'h3;

  // ----------------------------------------------------------------
  // Event bits
  // ----------------------------------------------------------------
  localparam int unsigned EV_STARTED = 0;
  localparam int unsigned EV_DONE = 1;
  localparam int unsigned EV_RESULTDONE = 2;
  localparam int unsigned EV_END = 3;
  localparam int unsigned EV_STOPPED = 4;
  localparam int unsigned EV_CALDONE = 5;
  localparam int unsigned EV_LIMH = 6;
  localparam int unsigned EV_LIML = 7;

  typedef enum logic [2:0] {
    S_IDLE, S_CAL, S_ACQ, S_CONV, S_STORE
  } fsm_t;

endpackage
`default_nettype wire

// ===== src/level_sync.sv
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_ff;
  sync_t nxt_st;

  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule
`default_nettype wire

// ===== src/result_shaper.sv
`timescale 1ns/10ps
`default_nettype none
module result_shaper (
  // Raw code, full scale is 2^14
  input wire logic [14:0] raw,
  // Settings
  input wire logic [1:0] res,
  input wire logic diff,
  input wire logic os_on,
  // Shaped result
  output logic [15:0] value
);
  logic [1:0] res_eff;
  logic [3:0] sh;
  logic signed [15:0] ext;

  always_comb begin
    // 14 bits only come from the accumulator
    res_eff = (res == sar_pkg::RES_14 && !os_on) ? 2'h2 : res;
    sh = 4'({res_eff, 1'b0} ^ 3'h6) + 4'(diff);
    ext = signed'({raw[14], raw});
    value = 16'(ext >>> sh);
  end
endmodule
`default_nettype wire

// ===== dv/analog_dma_model.sv
`timescale 1ns/10ps
`default_nettype none
module analog_dma_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Analog core
  input wire logic [3:0] core_pos_sel,
  input wire logic core_neg_gnd,
  input wire logic core_start,
  input wire logic core_calib,
  output logic core_done,
  output logic [14:0] core_code,
  // Result memory
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack
);
  logic [15:0] ram [0:15];
  logic [3:0] pos_log [0:15];
  logic gnd_log [0:15];
  logic [14:0] code_q;
  int nconv, nstore, busy, lag;
  // ----------------------------------------------------------------
  // Core and memory
  // ----------------------------------------------------------------
  // Pin 3 reads negative to expose sign handling; no pin is shared
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_done <= 1'b0;
      core_code <= 15'h2AAA;
      mem_ack <= 1'b0;
      nconv <= 0;
      nstore <= 0;
      busy <= 0;
      lag <= 0;
    end else begin
      if (core_start || core_calib) begin
        core_done <= 1'b0;
        // Alternate a quick and a slow core
        busy <= (nconv % 2 == 1) ? 40 : 6;
        code_q <= (core_pos_sel == 4'h3) ? 15'h7C40 :
          {3'h0, core_pos_sel, 8'h40};
      end else if (busy > 0) begin
        busy <= busy - 1;
        // Code toggles while converting, so a stale read shows
        core_code <= (busy == 2) ? code_q :
          ((busy > 2) ? ~core_code : core_code);
        core_done <= (busy == 1);
      end
      if (core_start) begin
        pos_log[nconv] <= core_pos_sel;
        gnd_log[nconv] <= core_neg_gnd;
        nconv <= nconv + 1;
      end
      mem_ack <= 1'b0;
      // Every second write is accepted late
      if (mem_req && !mem_ack) begin
        if (lag >= (nstore % 2) * 3) begin
          mem_ack <= 1'b1;
          ram[mem_addr[4:1]] <= mem_wdata;
          nstore <= nstore + 1;
          lag <= 0;
        end else begin
          lag <= lag + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mem_addr;
  logic sample_evt, core_neg_gnd, core_start, core_calib, core_done;
  logic mem_req, mem_ack, core_ref_sel;
  logic [7:0] events;
  logic [3:0] core_pos_sel, core_neg_sel;
  logic [2:0] core_gain;
  logic [14:0] core_code;
  logic [15:0] mem_wdata;
  logic [15:0] res_exp [4] = '{16'h0009, 16'h0024, 16'h0090, 16'h0090};
  int err_total, checked, n;
  localparam logic [11:0] CH1 = 12'h510;
  localparam logic [11:0] CH2 = 12'h520;

  sar_adc_ctrl DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sample_evt, .events,
    .core_pos_sel, .core_neg_sel, .core_neg_gnd, .core_gain,
    .core_ref_sel, .core_start, .core_calib, .core_done, .core_code,
    .mem_req, .mem_addr, .mem_wdata, .mem_ack);
  analog_dma_model peer (.ref_clk, .rst_n, .core_pos_sel, .core_neg_gnd,
    .core_start, .core_calib, .core_done, .core_code, .mem_req, .mem_addr,
    .mem_wdata, .mem_ack);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    // Values read here are those sampled at this rising edge
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_for(input int target);
    int k;
    k = 0;
    while (peer.nstore < target && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    if (peer.nstore < target) begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic ev(input int b, input logic e);
    apb(1'b0, sar_pkg::OFS_EVENTS, 32'h0);
    check("event flag", {31'h0, rd[b]}, {31'h0, e});
    apb(1'b1, sar_pkg::OFS_EVENTS, 32'h0000_00FF);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sample_evt = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, CH1 + 12'h8, 32'h0);
    check("config", rd, sar_pkg::CFG_RST);
    apb(1'b0, CH1 + 12'hC, 32'h0);
    check("limits", rd, sar_pkg::LIMIT_RST);
    apb(1'b0, sar_pkg::OFS_RESOLUTION, 32'h0);
    check("resolution", rd, {30'h0, sar_pkg::RES_RST});
    apb(1'b0, 12'h7FC, 32'h0);
    check("unmapped error", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h570, 32'h9);
    apb(1'b0, 12'h570, 32'h0);
    check("supply select", rd, {28'h0, sar_pkg::SEL_VDD});
    apb(1'b1, 12'h570, 32'h0);
    apb(1'b1, sar_pkg::OFS_TASK_START, 32'h1);
    apb(1'b1, sar_pkg::OFS_TASK_SAMPLE, 32'h1);
    repeat (300) @(posedge ref_clk);
    check("idle conversions", 32'(peer.nconv), 32'h0);
    ev(sar_pkg::EV_DONE, 1'b0);
    apb(1'b1, sar_pkg::OFS_RESULT_PTR, 32'h2000_0000);
    apb(1'b1, sar_pkg::OFS_MAXCNT, 32'h3);
    apb(1'b1, CH1, 32'h2);
    apb(1'b1, CH2, 32'h3);
    apb(1'b1, CH2 + 12'h4, 32'h4);
    // Channel 2 differential, longer acquisition, gain 5, other reference
    apb(1'b1, CH2 + 12'h8, 32'h0011_1500);
    apb(1'b0, sar_pkg::OFS_STATUS, 32'h0);
    check("scan flag", {31'h0, rd[5]}, 32'h1);
    apb(1'b1, sar_pkg::OFS_TASK_START, 32'h1);
    apb(1'b1, sar_pkg::OFS_TASK_SAMPLE, 32'h1);
    wait_for(2);
    check("entry 0", {16'h0, peer.ram[0]}, 32'h24);
    check("entry 1", {16'h0, peer.ram[1]}, 32'hFFE2);
    check("channel 0", {28'h0, peer.pos_log[0]}, 32'h2);
    check("channel 1", {28'h0, peer.pos_log[1]}, 32'h3);
    check("ground se", {31'h0, peer.gnd_log[0]}, 32'h1);
    check("ground diff", {31'h0, peer.gnd_log[1]}, 32'h0);
    check("neg select", {28'h0, core_neg_sel}, 32'h4);
    check("gain", {29'h0, core_gain}, 32'h5);
    check("reference", {31'h0, core_ref_sel}, 32'h1);
    @(posedge ref_clk);
    sample_evt <= 1'b1;
    @(posedge ref_clk);
    sample_evt <= 1'b0;
    wait_for(3);
    check("entry 2", {16'h0, peer.ram[2]}, 32'h24);
    ev(sar_pkg::EV_END, 1'b1);
    apb(1'b0, sar_pkg::OFS_AMOUNT, 32'h0);
    check("amount", rd, 32'h3);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, sar_pkg::OFS_TASK_STOP, 32'h1);
      ev(sar_pkg::EV_STOPPED, 1'b1);
    end
    apb(1'b1, sar_pkg::OFS_TASK_CAL, 32'h1);
    n = 0;
    do begin
      apb(1'b0, sar_pkg::OFS_EVENTS, 32'h0);
      n++;
    end while (rd[sar_pkg::EV_CALDONE] !== 1'b1 && n < 50);
    check("calibration", {31'h0, rd[sar_pkg::EV_CALDONE]}, 32'h1);
    apb(1'b1, CH2, 32'h0);
    apb(1'b0, sar_pkg::OFS_STATUS, 32'h0);
    check("one-shot flag", {31'h0, rd[5]}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, sar_pkg::OFS_RESOLUTION, 32'(i));
      apb(1'b1, sar_pkg::OFS_TASK_START, 32'h1);
      n = peer.nstore + 1;
      apb(1'b1, sar_pkg::OFS_TASK_SAMPLE, 32'h1);
      wait_for(n);
      check("scaled", {16'h0, peer.ram[0]}, {16'h0, res_exp[i]});
    end
    // Timer paced, four-fold oversampled run, high limit set low
    apb(1'b1, CH1 + 12'hC, 32'h0010_0000);
    apb(1'b1, sar_pkg::OFS_OVERSAMPLE, 32'h2);
    apb(1'b1, sar_pkg::OFS_SAMPLERATE, 32'h0000_1032);
    apb(1'b1, sar_pkg::OFS_EVENTS, 32'h0000_00FF);
    n = peer.nstore + 3;
    apb(1'b1, sar_pkg::OFS_TASK_START, 32'h1);
    wait_for(n);
    check("oversampled", {16'h0, peer.ram[2]}, 32'h240);
    apb(1'b0, sar_pkg::OFS_AMOUNT, 32'h0);
    check("timer amount", rd, 32'h3);
    apb(1'b0, sar_pkg::OFS_EVENTS, 32'h0);
    check("above limit", {31'h0, rd[sar_pkg::EV_LIMH]}, 32'h1);
    check("stored", {31'h0, rd[sar_pkg::EV_RESULTDONE]}, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
